// ---- prox_map.svh ----
// Offsets, field positions, encodings and timing counts of the proximity back end
`ifndef PROX_MAP_SVH
`define PROX_MAP_SVH

`define PROX_CMD_LOW_THRESHOLD  8'h06
`define PROX_CMD_HIGH_THRESHOLD 8'h07
`define PROX_THRESHOLD_W        16
`define PROX_STATUS_W           3
`define PROX_FLAG_FAR           0
`define PROX_FLAG_NEAR          1
`define PROX_FLAG_SUN           2
`define PROX_INT_NEAR           0
`define PROX_INT_FAR            1
`define PROX_CLK_MHZ            10
`define PROX_PERIOD_US          1000
`define PROX_PERIOD_CYCLES      (`PROX_PERIOD_US * `PROX_CLK_MHZ)

`endif

// ---- prox_pkg.sv ----
// Types shared by the proximity back end
package prox_pkg;

  typedef enum logic [1:0] {
    PROX_IDLE = 2'b00,
    PROX_BUSY = 2'b01
  } prox_seq_e;

  typedef logic [15:0] prox_word_t;

endpackage : prox_pkg

// ---- prox_int.sv ----
// Proximity threshold, persistence, offset and alert pin logic
`timescale 1ns/1ps
`include "prox_map.svh"

module prox_int
  import prox_pkg::*;
#(
  parameter int PERIOD_CYCLES = `PROX_PERIOD_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_link,
  input  wire logic        forced_mode_enable,
  input  wire logic        single_shot_trigger,
  input  wire logic [15:0] low_threshold,
  input  wire logic [15:0] high_threshold,
  input  wire logic [1:0]  persistence_count,
  input  wire logic [15:0] crosstalk_offset,
  input  wire logic [1:0]  interrupt_select,
  input  wire logic        detection_mechanism_select,
  input  wire logic        logic_output_select,
  input  wire logic        status_read,
  input  wire logic        raw_valid,
  input  wire logic [15:0] raw_data,
  input  wire logic        sunlight_detect,
  output logic             conv_start,
  output logic [15:0]      prox_data,
  output logic             data_ready,
  output logic [2:0]       status_flags,
  output logic             prox_near,
  output logic             alert_out,
  output logic             alert_oe
);

  localparam int PW = $clog2(PERIOD_CYCLES + 1);

  //----------------------------------------------------------------
  // Measurement sequencer (system clock)
  //----------------------------------------------------------------
  prox_seq_e     seq;
  prox_seq_e     next_seq;
  logic [PW-1:0] period_cnt;
  logic          trig_pend;
  logic          req_tgl;
  logic          done_s1;
  logic          done_s2;
  logic          done_s3;
  wire           done_evt;
  wire           period_hit;
  wire           want_meas;
  wire           issue;

  assign done_evt   = done_s2 ^ done_s3;
  assign period_hit = (period_cnt == PW'(PERIOD_CYCLES - 1));
  // Forced mode: only a pending trigger starts a conversion
  assign want_meas  = forced_mode_enable ? trig_pend : period_hit;
  assign issue      = (seq == PROX_IDLE) && want_meas;

  always_comb begin
    next_seq = seq;
    case (seq)
      PROX_IDLE: begin
        if (issue) begin
          next_seq = PROX_BUSY;
        end
      end
      PROX_BUSY: begin
        if (done_evt) begin
          next_seq = PROX_IDLE;
        end
      end
      default: begin
        next_seq = PROX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seq <= PROX_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  // Period timer is cleared and held at zero in forced mode
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_cnt <= '0;
    end else if (forced_mode_enable || period_hit) begin
      period_cnt <= '0;
    end else begin
      period_cnt <= period_cnt + PW'(1);
    end
  end

  // One trigger, one result; a new trigger wins over the consume
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trig_pend <= 1'b0;
    end else if (forced_mode_enable && single_shot_trigger) begin
      trig_pend <= 1'b1;
    end else if (issue || !forced_mode_enable) begin
      trig_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req_tgl <= 1'b0;
    end else if (issue) begin
      req_tgl <= ~req_tgl;
    end
  end

  //----------------------------------------------------------------
  // Link domain: start pulse out, raw word back
  //----------------------------------------------------------------
  logic       req_l1;
  logic       req_l2;
  logic       req_l3;
  logic       done_tgl;
  prox_word_t raw_hold;

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      req_l1     <= 1'b0;
      req_l2     <= 1'b0;
      req_l3     <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      req_l1     <= req_tgl;
      req_l2     <= req_l1;
      req_l3     <= req_l2;
      conv_start <= req_l2 ^ req_l3;
    end
  end

  // Raw word held steady until the next conversion returns
  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      raw_hold <= '0;
      done_tgl <= 1'b0;
    end else if (raw_valid) begin
      raw_hold <= raw_data;
      done_tgl <= ~done_tgl;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else begin
      done_s1 <= done_tgl;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  //----------------------------------------------------------------
  // Offset removal and output data
  //----------------------------------------------------------------
  wire        under;
  prox_word_t result;

  assign under  = raw_hold < crosstalk_offset;
  assign result = under ? '0 : raw_hold - crosstalk_offset;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prox_data  <= '0;
      data_ready <= 1'b0;
    end else begin
      data_ready <= done_evt;
      if (done_evt) begin
        prox_data <= result;
      end
    end
  end

  //----------------------------------------------------------------
  // Threshold compare with persistence, channel 0 near, 1 far
  //----------------------------------------------------------------
  wire [1:0] beyond;
  wire [1:0] met;
  wire [1:0] event_hit;
  logic      near_state;

  assign beyond[`PROX_INT_NEAR] = result > high_threshold;
  assign beyond[`PROX_INT_FAR]  = result < low_threshold;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_pers
      logic [2:0] run;
      wire        run_full;

      assign run_full = (run == {1'b0, persistence_count} + 3'h1);
      assign met[ch]  = done_evt && beyond[ch] &&
                        (run == {1'b0, persistence_count});

      // Consecutive count; any result inside the band resets it
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          run <= 3'h0;
        end else if (done_evt) begin
          if (!beyond[ch]) begin
            run <= 3'h0;
          end else if (!run_full) begin
            run <= run + 3'h1;
          end
        end
      end
    end
  endgenerate

  // With mechanism select high an event fires only on a change of state
  assign event_hit[`PROX_INT_NEAR] = met[`PROX_INT_NEAR] &&
         (!detection_mechanism_select || !near_state);
  assign event_hit[`PROX_INT_FAR]  = met[`PROX_INT_FAR] &&
         (!detection_mechanism_select || near_state);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      near_state <= 1'b0;
    end else if (met[`PROX_INT_NEAR]) begin
      near_state <= 1'b1;
    end else if (met[`PROX_INT_FAR]) begin
      near_state <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Sunlight input from the front end pin
  //----------------------------------------------------------------
  logic sun_s1;
  logic sun_s2;
  logic sun_s3;
  wire  sun_rise;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sun_s1 <= 1'b0;
      sun_s2 <= 1'b0;
      sun_s3 <= 1'b0;
    end else begin
      sun_s1 <= sunlight_detect;
      sun_s2 <= sun_s1;
      sun_s3 <= sun_s2;
    end
  end

  assign sun_rise = sun_s2 && !sun_s3;

  //----------------------------------------------------------------
  // Status flags, clear on read, set wins
  //----------------------------------------------------------------
  wire [2:0] set_flag;
  wire [2:0] next_flags;

  assign set_flag[`PROX_FLAG_NEAR] = event_hit[`PROX_INT_NEAR];
  assign set_flag[`PROX_FLAG_FAR]  = event_hit[`PROX_INT_FAR];
  assign set_flag[`PROX_FLAG_SUN]  = sun_rise;
  // Read returns current flags; they clear on the following edge
  assign next_flags = (status_read ? 3'h0 : status_flags) | set_flag;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_flags <= 3'h0;
    end else begin
      status_flags <= next_flags;
    end
  end

  //----------------------------------------------------------------
  // Alert pin, open drain, active low
  //----------------------------------------------------------------
  wire [2:0] int_mask;
  wire       int_cond;
  wire       next_near;
  wire       next_alert;

  // Interrupt select picks near, far or both crossings
  assign int_mask[`PROX_FLAG_NEAR] = interrupt_select[`PROX_INT_NEAR];
  assign int_mask[`PROX_FLAG_FAR]  = interrupt_select[`PROX_INT_FAR];
  assign int_mask[`PROX_FLAG_SUN]  = |interrupt_select;
  assign int_cond   = |(next_flags & int_mask);
  assign next_near  = met[`PROX_INT_NEAR] ||
                      (near_state && !met[`PROX_INT_FAR]);
  assign next_alert = logic_output_select ? next_near :
                      int_cond;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      alert_oe  <= 1'b0;
      alert_out <= 1'b0;
      prox_near <= 1'b0;
    end else begin
      alert_oe  <= next_alert;
      alert_out <= 1'b0;
      prox_near <= next_near;
    end
  end

endmodule : prox_int

// ---- prox_int_properties.sv ----
// Port checks on the proximity back end
`timescale 1ns/1ps
module prox_int_properties (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        forced_mode_enable,
  input wire logic        single_shot_trigger,
  input wire logic [15:0] low_threshold,
  input wire logic [15:0] high_threshold,
  input wire logic [1:0]  persistence_count,
  input wire logic [1:0]  interrupt_select,
  input wire logic        logic_output_select,
  input wire logic        status_read,
  input wire logic [15:0] prox_data,
  input wire logic        data_ready,
  input wire logic [2:0]  status_flags,
  input wire logic        prox_near,
  input wire logic        alert_out,
  input wire logic        alert_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [2:0] hi_run, lo_run;
  logic [7:0] idle;
  // Runs of earlier results beyond each threshold
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hi_run <= 3'h0;
      lo_run <= 3'h0;
    end else if (data_ready) begin
      hi_run <= (prox_data > high_threshold) ? hi_run + {2'h0, hi_run != 3'h7} : 3'h0;
      lo_run <= (prox_data < low_threshold) ? lo_run + {2'h0, lo_run != 3'h7} : 3'h0;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) idle <= 8'h00;
    else if (single_shot_trigger || !forced_mode_enable) idle <= 8'h00;
    else if (idle != 8'hff) idle <= idle + 8'h01;
  end
  AST_ALERT_MAP: assert property (!$past(logic_output_select) |-> alert_oe ==
    |(status_flags & {|$past(interrupt_select), $past(interrupt_select[0]),
    $past(interrupt_select[1])})) else $error("alert map");
  AST_LOGIC_OUT: assert property ($past(logic_output_select) |-> alert_oe == prox_near)
    else $error("logic output");
  AST_NEAR_CAUSE: assert property ($rose(status_flags[1]) |-> data_ready &&
    prox_data > high_threshold && hi_run >= {1'b0, persistence_count}) else $error("near flag");
  AST_FAR_CAUSE: assert property ($rose(status_flags[0]) |-> data_ready &&
    prox_data < low_threshold && lo_run >= {1'b0, persistence_count}) else $error("far flag");
  AST_CLEAR: assert property (status_read |=> data_ready || status_flags[1:0] == 2'b00)
    else $error("read clear");
  AST_FORCED: assert property (data_ready |-> idle < 8'd60) else $error("forced idle");
  AST_ONE_RESULT: assert property (data_ready |=> !data_ready [*3]) else $error("pulse");
  AST_PIN_LEVEL: assert property (alert_oe |-> alert_out == 1'b0) else $error("pin");
  cover property ($rose(status_flags[1]));
  cover property ($rose(status_flags[0]));
  cover property (forced_mode_enable && data_ready);
  cover property (logic_output_select && alert_oe);
endmodule : prox_int_properties

bind prox_int prox_int_properties chk_u (.*);

// ---- prox_front_model.sv ----
// Behavioural front end answering each conversion start
`timescale 1ns/1ps
module prox_front_model (
  input  wire logic        clk_link,
  input  wire logic        conv_start,
  input  wire logic [15:0] raw_value,
  input  wire logic [31:0] delay,
  output logic             raw_valid,
  output logic [15:0]      raw_data
);
  int cnt = 0;
  initial raw_valid = 1'b0;
  initial raw_data = 16'h0000;
  // Data bus toggles outside the strobe
  always @(posedge clk_link) begin
    raw_valid <= 1'b0;
    raw_data <= ~raw_data;
    if (conv_start) cnt <= delay;
    else if (cnt > 0) cnt <= cnt - 1;
    if (!conv_start && cnt == 1) begin
      raw_valid <= 1'b1;
      raw_data <= raw_value;
    end
  end
endmodule : prox_front_model

// ---- prox_int_tb_top.sv ----
// Self-checking bench for the proximity back end
`timescale 1ns/1ps
module prox_int_tb_top;
  import prox_pkg::*;
  logic        clk_sys = 0, clk_link = 0, rstn = 0, forced = 0, trig = 0, lsel = 0, rd = 0;
  logic        sun = 0, dms = 1;
  logic [15:0] lo = 16'h0100, hi = 16'h0400, off = 16'h0020, rv = 16'h0000;
  logic [1:0]  pers = 2'd2, isel = 2'b01;
  logic        raw_valid, conv_start, data_ready, prox_near, alert_out, alert_oe;
  logic [15:0] raw_data, prox_data, d;
  logic [2:0]  status_flags, exp_fl = 3'b000;
  logic [15:0] q[$];
  int          miscompares = 0, cmp_count = 0, n_res = 0, hi_run = 0, lo_run = 0, dly = 4, t;
  bit          near_st = 0;
  int          seed = 32'h8c606f0b;
  always #50 clk_sys = ~clk_sys;
  always #3 clk_link = ~clk_link;
  prox_int #(.PERIOD_CYCLES(20)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link),
    .forced_mode_enable(forced), .single_shot_trigger(trig), .low_threshold(lo),
    .high_threshold(hi), .persistence_count(pers), .crosstalk_offset(off),
    .interrupt_select(isel), .detection_mechanism_select(dms), .logic_output_select(lsel),
    .status_read(rd), .raw_valid(raw_valid), .raw_data(raw_data), .sunlight_detect(sun),
    .conv_start(conv_start), .prox_data(prox_data), .data_ready(data_ready),
    .status_flags(status_flags), .prox_near(prox_near), .alert_out(alert_out),
    .alert_oe(alert_oe));
  prox_front_model fm_u (.clk_link(clk_link), .conv_start(conv_start), .raw_value(rv),
    .delay(dly), .raw_valid(raw_valid), .raw_data(raw_data));
  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  always @(posedge clk_link) if (raw_valid) q.push_back(raw_data);
  always @(posedge clk_sys) if (data_ready) begin
    d = q.pop_front();
    d = d > off ? d - off : 16'h0000;
    chk_data(prox_data, d);
    hi_run = d > hi ? hi_run + 1 : 0;
    lo_run = d < lo ? lo_run + 1 : 0;
    if (hi_run > pers && !near_st) begin
      near_st = 1;
      exp_fl[1] = 1'b1;
    end
    if (lo_run > pers && near_st) begin
      near_st = 0;
      exp_fl[0] = 1'b1;
    end
    chk_flags({1'b0, status_flags[1:0]}, {1'b0, exp_fl[1:0]});
    n_res++;
  end
  task automatic report(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : report
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    report(got, exp, "data");
  endtask : chk_data
  task automatic chk_flags(input logic [2:0] got, input logic [2:0] exp);
    report({13'h0, got}, {13'h0, exp}, "flags");
  endtask : chk_flags
  task automatic chk_pin(input logic got, input logic exp);
    report({15'h0, got}, {15'h0, exp}, "pin");
  endtask : chk_pin
  task automatic chk_count(input logic [15:0] got, input logic [15:0] exp);
    report(got, exp, "count");
  endtask : chk_count
  task automatic results(input logic [15:0] v, input int n);
    rv = v;
    dly = 1 + $unsigned($random(seed)) % 20;
    t = n_res + n;
    for (int i = 0; i < 5000 && n_res < t; i++) @(negedge clk_sys);
    chk_count(16'(n_res), 16'(t));
  endtask : results
  task automatic read_flags(input string s);
    logic al;
    al = lsel ? near_st : |(exp_fl & {|isel, isel[0], isel[1]});
    chk_flags(status_flags, exp_fl);
    chk_pin(alert_oe, al);
    chk_pin(prox_near, near_st);
    rd = 1;
    @(negedge clk_sys) rd = 0;
    exp_fl = 3'b000;
    @(negedge clk_sys);
    chk_flags(status_flags, 3'b000);
    chk_pin(alert_oe, lsel & near_st);
    chk_pin(prox_near, near_st);
    $display("test %s done", s);
  endtask : read_flags
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk_sys);
    rstn = 1;
    for (int i = 0; i < 6; i++) results(lo + off + 1 + $unsigned($random(seed)) % (hi - lo - 1), 1);
    results(16'h0800, 4);
    read_flags("near");
    for (int m = 0; m < 4; m++) begin
      isel = m[1:0];
      lsel = m == 3;
      results(16'h0010, 4);
      results(16'h0800, 4);
      read_flags("mask");
    end
    lsel = 0;
    isel = 2'b01;
    sun = 1;
    exp_fl[2] = 1'b1;
    repeat (8) @(negedge clk_sys);
    read_flags("sun");
    sun = 0;
    forced = 1;
    repeat (260) @(negedge clk_sys);
    t = n_res;
    for (int i = 0; i < 2; i++) begin
      trig = 1;
      @(negedge clk_sys) trig = 0;
      repeat (100) @(negedge clk_sys);
      chk_count(16'(n_res), 16'(t + i + 1));
    end
    $display("test forced done");
    end_sim();
  end
  initial begin
    #2_000_000;
    miscompares++;
    $display("[FAIL] %0t watchdog", $time);
    end_sim();
  end
endmodule : prox_int_tb_top
